// *** cell_overcharge_protect_fsm.sv ***
// Overcharge protection state logic for a 2- to 4-cell pack
// Assumes comparator outputs and override pin arrive as digital levels
`timescale 1ns/1ps
// Operation
// - Below threshold plus hysteresis on all cells, output sits inactive.
// - Cell above threshold for full detection delay inverts output.
// - Release only after all cells below release level for release delay.
// - Dip shorter than timer-reset delay keeps detection count running.
// - Dip of timer-reset delay or longer clears count; restart on next rise.
// - Override input takes priority over detection result.
// - Override high lets machine drive; low or open forces detection.
// - Supply held high for test-entry time enables shortened detection delay.
// - Test mode is latched and survives supply return.
// - Detection after delay clears the test latch.
// - Timer-reset delay keeps normal length in test mode.
module cell_overcharge_protect_fsm
   import ovc_pkg::*;
#(
   parameter bit ACTIVE_HIGH = 1'b1,
   parameter bit TIMER_RESET_EN = 1'b1,
   parameter int unsigned DETECT_TICKS = DETECT_DELAY_MS,
   parameter int unsigned DETECT_TEST_TICKS = DETECT_DELAY_TEST_MS,
   parameter int unsigned RELEASE_TICKS = RELEASE_DELAY_MS,
   parameter int unsigned TRESET_TICKS = TIMER_RESET_DELAY_MS,
   parameter int unsigned TEST_TICKS = TEST_ENTRY_MS
) (
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic [ovc_pkg::CELLS-1:0] cell_over_thr,
   input  wire logic [ovc_pkg::CELLS-1:0] cell_over_rel,
   input  wire logic                      output_override_in,
   input  wire logic                      test_entry_level,
   output logic                           charge_ctrl_out,
   output logic                           overcharge_status,
   output logic                           test_mode
);
   import ovc_pkg::*;

   typedef struct packed {
      ovc_state_t       state;
      logic [CNT_W-1:0] det_cnt;
      logic [CNT_W-1:0] dip_cnt;
      logic [CNT_W-1:0] rel_cnt;
      logic [CNT_W-1:0] tst_cnt;
      logic             test_latch;
      logic             out_pin;
   } core_t;

   core_t st_reg;
   core_t st_next;
   ovc_sig_if sig ();

   logic any_over;
   logic any_rel;
   logic [CNT_W-1:0] det_limit;
   logic detect_now;

   // ----------------------------------------
   // Front end
   // ----------------------------------------
   ovc_front u_front (
      .core_clk           (core_clk),
      .rst_b              (rst_b),
      .cell_over_thr      (cell_over_thr),
      .cell_over_rel      (cell_over_rel),
      .output_override_in (output_override_in),
      .test_entry_level   (test_entry_level),
      .sig                (sig.src)
   );

   assign any_over  = |sig.above_thr;
   assign any_rel   = |sig.above_rel;
   assign det_limit = st_reg.test_latch ? CNT_W'(DETECT_TEST_TICKS)
                                        : CNT_W'(DETECT_TICKS);

   // ----------------------------------------
   // Next state
   // ----------------------------------------
   always_comb begin
      st_next    = st_reg;
      detect_now = 1'b0;
      // Test entry filter
      if (!sig.test_req) begin
         st_next.tst_cnt = CNT_ZERO;
      end else if (sig.tick && st_reg.tst_cnt != CNT_W'(TEST_TICKS)) begin
         st_next.tst_cnt = st_reg.tst_cnt + CNT_ONE;
      end
      if (sig.test_req && st_reg.tst_cnt == CNT_W'(TEST_TICKS)) begin
         st_next.test_latch = 1'b1;
      end
      case (st_reg.state)
         ST_NORMAL: begin
            st_next.det_cnt = CNT_ZERO;
            st_next.dip_cnt = CNT_ZERO;
            if (any_over) begin
               st_next.state = ST_COUNT;
            end
         end
         ST_COUNT: begin
            if (any_over) begin
               st_next.dip_cnt = CNT_ZERO;
               if (sig.tick) begin
                  st_next.det_cnt = st_reg.det_cnt + CNT_ONE;
               end
               if (sig.tick && st_reg.det_cnt + CNT_ONE >= det_limit) begin
                  detect_now    = 1'b1;
                  st_next.state = ST_CHARGED;
               end
            end else begin
               if (sig.tick) begin
                  st_next.dip_cnt = st_reg.dip_cnt + CNT_ONE;
                  st_next.det_cnt = st_reg.det_cnt + CNT_ONE;
               end
               if (!TIMER_RESET_EN || (sig.tick &&
                   st_reg.dip_cnt + CNT_ONE >= CNT_W'(TRESET_TICKS))) begin
                  st_next.det_cnt = CNT_ZERO;
                  st_next.state   = ST_NORMAL;
               end
            end
         end
         ST_CHARGED: begin
            if (any_rel) begin
               st_next.rel_cnt = CNT_ZERO;
            end else if (sig.tick) begin
               st_next.rel_cnt = st_reg.rel_cnt + CNT_ONE;
               if (st_reg.rel_cnt + CNT_ONE >= CNT_W'(RELEASE_TICKS)) begin
                  st_next.rel_cnt = CNT_ZERO;
                  st_next.state   = ST_NORMAL;
               end
            end
         end
         default: begin
            st_next.state = ST_NORMAL;
         end
      endcase
      if (detect_now) begin
         st_next.test_latch = 1'b0;
         st_next.tst_cnt    = CNT_ZERO;
      end
      if (st_next.state != ST_CHARGED) begin
         st_next.rel_cnt = CNT_ZERO;
      end
      // Override first, then detection result
      if (sig.override_hi && st_next.state != ST_CHARGED) begin
         st_next.out_pin = ACTIVE_HIGH ? 1'b0 : 1'b1;
      end else begin
         st_next.out_pin = ACTIVE_HIGH ? 1'b1 : 1'b0;
      end
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg         <= '0;
         st_reg.state   <= ST_NORMAL;
         st_reg.out_pin <= !ACTIVE_HIGH;
      end else begin
         st_reg <= st_next;
      end
   end

   assign charge_ctrl_out   = st_reg.out_pin;
   assign overcharge_status = (st_reg.state == ST_CHARGED);
   assign test_mode         = st_reg.test_latch;
endmodule // cell_overcharge_protect_fsm

// *** cell_overcharge_protect_fsm_tb.sv ***
// Testbench for the overcharge protection block
// Assumes the far-side model and the bound checker are compiled first
`timescale 1ns/1ps
module cell_overcharge_protect_fsm_tb;
   import ovc_pkg::*;
   localparam int DET = 2;
   localparam int REL = 2;
   localparam int TST = 1;
   typedef struct packed {logic ovr; logic open; logic [3:0] rel; logic test; logic exp;} row_t;
   logic             core_clk, rst_b, ovr_want, ovr_open, test_want;
   logic [CELLS-1:0] thr_want, rel_extra, cell_over_thr, cell_over_rel;
   logic             output_override_in, test_entry_level;
   logic             charge_ctrl_out, overcharge_status, test_mode;
   int               bad_count, comparisons, cyc;
   row_t             rows [4] = '{8'h80, 8'h03, 8'hBC, 8'hC1};
   cell_overcharge_protect_fsm #(.DETECT_TICKS(DET), .DETECT_TEST_TICKS(TST),
      .RELEASE_TICKS(REL), .TRESET_TICKS(2), .TEST_TICKS(TST)) dut (
      .core_clk(core_clk), .rst_b(rst_b), .cell_over_thr(cell_over_thr),
      .cell_over_rel(cell_over_rel), .output_override_in(output_override_in),
      .test_entry_level(test_entry_level), .charge_ctrl_out(charge_ctrl_out),
      .overcharge_status(overcharge_status), .test_mode(test_mode));
   ovc_far_side far (.thr_mask(1'b1), .thr_want(thr_want), .rel_extra(rel_extra),
      .ovr_want(ovr_want), .ovr_open(ovr_open), .test_want(test_want),
      .cell_over_thr(cell_over_thr), .cell_over_rel(cell_over_rel),
      .output_override_in(output_override_in), .test_entry_level(test_entry_level));
   task automatic check(input string name, input logic seen, input logic exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("wrong value %s expected %b seen %b", name, exp, seen);
      end
   endtask
   task automatic end_sim;
      $display("comparisons %0d bad_count %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic wait_status(input logic want, input int limit);
      cyc = 0;
      while (overcharge_status !== want && cyc < limit) begin
         @(negedge core_clk);
         cyc++;
      end
      if (cyc >= limit) begin
         bad_count++;
         end_sim;
      end
   endtask
   initial begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end
   initial begin
      rst_b = 1'b1;
      ovr_want = 1'b1;
      ovr_open = 1'b0;
      test_want = 1'b0;
      thr_want = '0;
      rel_extra = '0;
      bad_count = 0;
      comparisons = 0;
      #5 rst_b = 1'b0;
      repeat (10) @(posedge core_clk);
      check("reset out", charge_ctrl_out, 1'b0);
      rst_b <= 1'b1;
      $display("reset test done");
      foreach (rows[i]) begin
         @(posedge core_clk);
         ovr_want <= rows[i].ovr;
         ovr_open <= rows[i].open;
         rel_extra <= rows[i].rel;
         test_want <= rows[i].test;
         repeat (6) @(negedge core_clk);
         check("row out", charge_ctrl_out, rows[i].exp);
      end
      $display("row tests done");
      check("short entry", test_mode, 1'b0);
      @(posedge core_clk);
      ovr_open <= 1'b0;
      test_want <= 1'b1;
      cyc = 0;
      while (test_mode !== 1'b1 && cyc < (TST + 2) * TICK_CYC) begin
         @(negedge core_clk);
         cyc++;
      end
      check("test entry", test_mode, 1'b1);
      @(posedge core_clk);
      test_want <= 1'b0;
      repeat (6) @(negedge core_clk);
      check("test latch", test_mode, 1'b1);
      @(posedge core_clk);
      thr_want <= 4'h4;
      wait_status(1'b1, (TST + 2) * TICK_CYC);
      check("detect time", cyc <= (TST + 1) * TICK_CYC + 8, 1'b1);
      repeat (3) @(negedge core_clk);
      check("detect out", charge_ctrl_out, 1'b1);
      check("test exit", test_mode, 1'b0);
      $display("detect test done");
      @(posedge core_clk);
      thr_want <= 4'h0;
      wait_status(1'b0, (REL + 2) * TICK_CYC);
      check("release time", cyc >= (REL - 1) * TICK_CYC && cyc <= (REL + 1) * TICK_CYC + 8, 1'b1);
      repeat (3) @(negedge core_clk);
      check("release out", charge_ctrl_out, 1'b0);
      $display("release test done");
      @(posedge core_clk);
      ovr_want <= 1'b0;
      rst_b <= 1'b0;
      repeat (3) @(negedge core_clk);
      check("second reset out", charge_ctrl_out, 1'b0);
      @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) @(negedge core_clk);
      check("sync delay", charge_ctrl_out, 1'b0);
      @(negedge core_clk);
      check("forced out", charge_ctrl_out, 1'b1);
      $display("second reset test done");
      end_sim;
   end
endmodule // cell_overcharge_protect_fsm_tb

// *** ovc_far_side.sv ***
// Far-side model: cell comparators, supply comparator, override source
// Assumes the bench sets the wanted levels on the rising edge
`timescale 1ns/1ps
module ovc_far_side (
   input  wire logic                      thr_mask,
   input  wire logic [ovc_pkg::CELLS-1:0] thr_want,
   input  wire logic [ovc_pkg::CELLS-1:0] rel_extra,
   input  wire logic                      ovr_want,
   input  wire logic                      ovr_open,
   input  wire logic                      test_want,
   output logic      [ovc_pkg::CELLS-1:0] cell_over_thr,
   output logic      [ovc_pkg::CELLS-1:0] cell_over_rel,
   output logic                           output_override_in,
   output logic                           test_entry_level
);
   assign cell_over_thr      = thr_mask ? thr_want : '0;
   assign cell_over_rel      = cell_over_thr | rel_extra;  // Release level at or below
   assign output_override_in = ovr_want && !ovr_open;      // Open pin pulled low
   assign test_entry_level   = test_want;
endmodule // ovc_far_side

// *** ovc_front.sv ***
// Input front end: synchronisers and 1 ms time base
// Assumes raw comparator levels and override pin on inputs
`timescale 1ns/1ps
module ovc_front
   import ovc_pkg::*;
(
   input  wire logic             core_clk,
   input  wire logic             rst_b,
   input  wire logic [CELLS-1:0] cell_over_thr,
   input  wire logic [CELLS-1:0] cell_over_rel,
   input  wire logic             output_override_in,
   input  wire logic             test_entry_level,
   ovc_sig_if.src                sig
);
   typedef struct packed {
      logic [TICK_W-1:0] div;
      logic              tick;
   } front_t;
   front_t st_reg;
   front_t st_next;
   logic [2*CELLS+1:0] synced;

   // ----------------------------------------
   // Synchronisers
   // ----------------------------------------
   ovc_sync #(.W(2*CELLS+2)) u_sync (
      .core_clk (core_clk),
      .rst_b    (rst_b),
      .d        ({test_entry_level, ~output_override_in, cell_over_rel, cell_over_thr}),
      .q        (synced)
   );

   // ----------------------------------------
   // Time base
   // ----------------------------------------
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (st_reg.div == TICK_W'(TICK_CYC - 1)) begin
         st_next.div  = TICK_ZERO;
         st_next.tick = 1'b1;
      end else begin
         st_next.div = st_reg.div + TICK_ONE;
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign sig.above_thr   = synced[CELLS-1:0];
   assign sig.above_rel   = synced[2*CELLS-1:CELLS];
   // Inverted through the flops so a reset synchroniser reads as override high
   assign sig.override_hi = ~synced[2*CELLS];
   assign sig.test_req    = synced[2*CELLS+1];
   assign sig.tick        = st_reg.tick;
endmodule // ovc_front

// *** ovc_pkg.sv ***
// Constants and types for the overcharge protection block
// Assumes a 20 MHz core clock and asynchronous digital inputs, synchronised in the front end
package ovc_pkg;
   // ----------------------------------------
   // Clock and time base
   // ----------------------------------------
   localparam int unsigned CLK_HZ          = 20000000;
   localparam int unsigned TICK_US         = 1000;
   localparam int unsigned TICK_CYC        = (CLK_HZ / 1000000) * TICK_US;
   localparam int          TICK_W          = 15;
   localparam int          CELLS           = 4;
   localparam int          CNT_W           = 14;
   // ----------------------------------------
   // Delays in time-base ticks of 1 ms
   // ----------------------------------------
   localparam int unsigned DETECT_DELAY_MS      = 1000;
   localparam int unsigned DETECT_DELAY_TEST_MS = 10;
   localparam int unsigned RELEASE_DELAY_MS     = 64;
   localparam int unsigned TIMER_RESET_DELAY_MS = 16;
   localparam int unsigned TEST_ENTRY_MS        = 10;
   localparam logic [CNT_W-1:0] CNT_ZERO        = 14'h0000;
   localparam logic [CNT_W-1:0] CNT_ONE         = 14'h0001;
   localparam logic [TICK_W-1:0] TICK_ZERO      = 15'h0000;
   localparam logic [TICK_W-1:0] TICK_ONE       = 15'h0001;

   typedef enum logic [2:0] {
      ST_NORMAL  = 3'b001,
      ST_COUNT   = 3'b010,
      ST_CHARGED = 3'b100
   } ovc_state_t;
endpackage

// *** ovc_props.sv ***
// Checker for the overcharge protection block
// Assumes bind onto the top module, one clock domain
`timescale 1ns/1ps
module ovc_props #(
   parameter bit          ACTIVE_HIGH       = 1'b1,
   parameter int unsigned DETECT_TEST_TICKS = 10,
   parameter int unsigned RELEASE_TICKS     = 64,
   parameter int unsigned TRESET_TICKS      = 16,
   parameter int unsigned TEST_TICKS        = 10
) (
   input wire logic                      core_clk,
   input wire logic                      rst_b,
   input wire logic [ovc_pkg::CELLS-1:0] cell_over_thr,
   input wire logic [ovc_pkg::CELLS-1:0] cell_over_rel,
   input wire logic                      output_override_in,
   input wire logic                      test_entry_level,
   input wire logic                      charge_ctrl_out,
   input wire logic                      overcharge_status,
   input wire logic                      test_mode
);
   import ovc_pkg::*;
   int rel_low, thr_low, arm, entry_hi;
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         rel_low  <= 0;
         thr_low  <= 0;
         arm      <= 0;
         entry_hi <= 0;
      end else begin
         rel_low  <= (|cell_over_rel) ? 0 : rel_low + 1;
         thr_low  <= (|cell_over_thr) ? 0 : thr_low + 1;
         entry_hi <= test_entry_level ? entry_hi + 1 : 0;
         if (overcharge_status || thr_low > (TRESET_TICKS + 1) * TICK_CYC) arm <= 0;
         else if ((|cell_over_thr) || arm != 0) arm <= arm + 1;
      end
   end
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   sequence ovr_low_run; !output_override_in [*5]; endsequence
   sequence rel_held; (overcharge_status && (|cell_over_rel)) [*4]; endsequence
   chk_reset_idle:
   assert property (disable iff (1'b0) !rst_b |-> !overcharge_status && !test_mode
      && charge_ctrl_out == !ACTIVE_HIGH) else $error("outputs not idle in reset");
   chk_ovr_force:
   assert property (ovr_low_run |-> charge_ctrl_out == ACTIVE_HIGH)
      else $error("override low did not force detection");
   chk_ovr_follow:
   assert property (output_override_in [*5] |-> charge_ctrl_out == (overcharge_status ^ !ACTIVE_HIGH)
      || charge_ctrl_out == ($past(overcharge_status) ^ !ACTIVE_HIGH))
      else $error("output does not follow detection state");
   chk_release_hold:
   assert property (rel_held |=> overcharge_status) else $error("released with a cell high");
   chk_release_time:
   assert property ($fell(overcharge_status) |-> rel_low >= (RELEASE_TICKS - 1) * TICK_CYC)
      else $error("release delay too short");
   chk_detect_time:
   assert property ($rose(overcharge_status) |-> arm >= (DETECT_TEST_TICKS - 1) * TICK_CYC)
      else $error("detection delay too short");
   chk_test_entry:
   assert property ($rose(test_mode) |-> $past(entry_hi, 3) >= (TEST_TICKS - 1) * TICK_CYC)
      else $error("test mode entered too early");
   chk_test_latch:
   assert property ($fell(test_mode) |-> overcharge_status) else $error("test mode left early");
endmodule // ovc_props
bind cell_overcharge_protect_fsm ovc_props #(.ACTIVE_HIGH(ACTIVE_HIGH),
   .DETECT_TEST_TICKS(DETECT_TEST_TICKS), .RELEASE_TICKS(RELEASE_TICKS),
   .TRESET_TICKS(TRESET_TICKS), .TEST_TICKS(TEST_TICKS)) props_i (
   .core_clk(core_clk), .rst_b(rst_b), .cell_over_thr(cell_over_thr),
   .cell_over_rel(cell_over_rel), .output_override_in(output_override_in),
   .test_entry_level(test_entry_level), .charge_ctrl_out(charge_ctrl_out),
   .overcharge_status(overcharge_status), .test_mode(test_mode));

// *** ovc_sig_if.sv ***
// Bundle of synchronised inputs and the time-base tick passed between internal modules
// Assumes one clock domain
`timescale 1ns/1ps
interface ovc_sig_if;
   logic [ovc_pkg::CELLS-1:0] above_thr;
   logic [ovc_pkg::CELLS-1:0] above_rel;
   logic                      override_hi;
   logic                      test_req;
   logic                      tick;
   modport src (output above_thr, above_rel, override_hi, test_req, tick);
   modport dst (input above_thr, above_rel, override_hi, test_req, tick);
endinterface // ovc_sig_if

// *** ovc_sync.sv ***
// Two-flop synchroniser, one bit per lane
// Assumes asynchronous active-low reset
`timescale 1ns/1ps
module ovc_sync #(
   parameter int W = 1
) (
   input  wire logic         core_clk,
   input  wire logic         rst_b,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   typedef struct packed {
      logic [W-1:0] s1;
      logic [W-1:0] s2;
   } sync_t;
   sync_t st_reg;
   sync_t st_next;

   always_comb begin
      st_next    = st_reg;
      st_next.s1 = d;
      st_next.s2 = st_reg.s1;
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.s2;
endmodule // ovc_sync
